//--- rtl/drive_comm_pkg.sv
// Package: parameter map, field layouts and limits of the drive status registers
package drive_comm_pkg;

   // ----------------------------------------------------------------
   // Parameter addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_TRIP_FLAGS      = 16'h000F;
   localparam logic [15:0] ADDR_INPUT_TERM      = 16'h0010;
   localparam logic [15:0] ADDR_OUTPUT_TERM     = 16'h0011;
   localparam logic [15:0] ADDR_ANALOG_A        = 16'h0012;
   localparam logic [15:0] ADDR_ANALOG_B        = 16'h0013;
   localparam logic [15:0] ADDR_ANALOG_I        = 16'h0014;
   localparam logic [15:0] ADDR_SHAFT_SPEED     = 16'h0015;
   localparam logic [15:0] ADDR_UNIT_SELECT     = 16'h001A;
   localparam logic [15:0] ADDR_POLE_COUNT      = 16'h001B;
   localparam logic [15:0] ADDR_CUSTOM_REV      = 16'h001C;
   localparam logic [15:0] ADDR_CARD_TYPE       = 16'h9601;
   localparam logic [15:0] ADDR_CMD_SOURCE      = 16'h9602;
   localparam logic [15:0] ADDR_CARD_REV        = 16'h9603;
   localparam logic [15:0] ADDR_FRAMING         = 16'h963C;
   localparam logic [15:0] ADDR_SERIES_CODE     = 16'hFFFF;
   localparam logic [15:0] ADDR_COMMON_LAST     = 16'h001C;

   // ----------------------------------------------------------------
   // Field masks and widths
   // ----------------------------------------------------------------
   localparam logic [15:0] TRIP_USED_MASK       = 16'hF7DF;
   localparam int          INPUT_TERM_W         = 11;
   localparam int          OUTPUT_TERM_W        = 8;
   localparam int          CARD_TYPE_W          = 3;
   localparam int          SETTING_W            = 2;
   localparam int          RUN_W                = 2;

   // ----------------------------------------------------------------
   // Reset values and limits
   // ----------------------------------------------------------------
   localparam logic [1:0]  CMD_SOURCE_RESET     = 2'h0;
   localparam logic [1:0]  FRAMING_RESET        = 2'h0;
   localparam logic [2:0]  CARD_TYPE_RESET      = 3'h0;
   localparam logic [15:0] SETTING_MAX          = 16'h0003;
   localparam int          SRC_RUN_BIT          = 0;
   localparam int          SRC_FREQ_BIT         = 1;

endpackage

//--- rtl/level_sync.sv
// Two-flop synchroniser for a bundle of slow pin levels
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys_in,
   input  wire logic             rst_b_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_reg;

   // Only the second stage is visible outside
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_reg <= '0;
         q_out    <= '0;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end

endmodule

//--- rtl/drive_comm_status_registers.sv
// Drive parameter map: status words, option-card settings and command steering
//
// Notes on behaviour
// - The command-source selector comes out of reset at 0 and only takes values 0 to 3.
// - At selector 1 run/stop comes from the link while frequency stays local.
// - At selector 2 frequency comes from the link while run/stop stays local.
// - At selector 3 both run/stop and frequency come from the link.
// - The card-type word is filled in by the drive from the fitted card, 0 to 7, read only.
// - The card-type word reports which kind of option card is installed.
// - Common-area words here take no stored value; nothing written there survives a reset.
module drive_comm_status_registers #(
   parameter logic [15:0] SERIES_CODE = 16'h00A5  // Arbitrary identity value
) (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   input  wire logic        param_req_in,
   input  wire logic        param_wr_in,
   input  wire logic [15:0] param_addr_in,
   input  wire logic [15:0] param_wdata_in,
   output logic             param_ack_out,
   output logic             param_err_out,
   output logic      [15:0] param_rdata_out,
   input  wire logic [15:0] trip_cond_in,
   input  wire logic [10:0] input_term_in,
   input  wire logic [7:0]  output_term_in,
   input  wire logic        card_present_in,
   input  wire logic [2:0]  card_type_in,
   input  wire logic [15:0] card_revision_in,
   input  wire logic [15:0] analog_a_in,
   input  wire logic [15:0] analog_b_in,
   input  wire logic [15:0] analog_i_in,
   input  wire logic [15:0] shaft_speed_in,
   input  wire logic [15:0] unit_select_in,
   input  wire logic [15:0] pole_count_in,
   input  wire logic [15:0] custom_rev_in,
   input  wire logic [1:0]  local_run_in,
   input  wire logic [15:0] local_freq_in,
   input  wire logic [1:0]  link_run_in,
   input  wire logic [15:0] link_freq_in,
   output logic      [1:0]  run_cmd_out,
   output logic      [15:0] freq_cmd_out,
   output logic             run_from_link_out,
   output logic             freq_from_link_out,
   output logic      [1:0]  framing_sel_out
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   localparam int SYNC_W = 16 + drive_comm_pkg::INPUT_TERM_W + drive_comm_pkg::OUTPUT_TERM_W
                           + 1 + drive_comm_pkg::CARD_TYPE_W;

   logic [SYNC_W-1:0] sync_q;
   logic [15:0]       trip_sync;
   logic [10:0]       in_term_sync;
   logic [7:0]        out_term_sync;
   logic              present_sync;
   logic [2:0]        type_sync;

   level_sync #(.WIDTH(SYNC_W)) u_pin_sync (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .d_in       ({trip_cond_in, input_term_in, output_term_in, card_present_in,
                    card_type_in}),
      .q_out      (sync_q)
   );

   assign {trip_sync, in_term_sync, out_term_sync, present_sync, type_sync} = sync_q;

   // ----------------------------------------------------------------
   // Settings and card type
   // ----------------------------------------------------------------
   logic [1:0] cmd_src_reg;
   logic [1:0] cmd_src_next;
   logic [1:0] framing_reg;
   logic [1:0] framing_next;
   logic [2:0] card_type_reg;
   logic [2:0] card_type_next;

   function automatic logic in_range(input logic [15:0] value);
      in_range = (value <= drive_comm_pkg::SETTING_MAX);
   endfunction

   // Write strobes
   wire        wr_req    = param_req_in && param_wr_in;
   wire        hit_src   = (param_addr_in == drive_comm_pkg::ADDR_CMD_SOURCE);
   wire        hit_frame = (param_addr_in == drive_comm_pkg::ADDR_FRAMING);
   wire        wdata_ok  = in_range(param_wdata_in);
   wire        src_we    = wr_req && hit_src && wdata_ok;
   wire        frame_we  = wr_req && hit_frame && wdata_ok;

   assign cmd_src_next   = src_we ? param_wdata_in[1:0] : cmd_src_reg;
   assign framing_next   = frame_we ? param_wdata_in[1:0] : framing_reg;
   // No card fitted reads as type 0
   assign card_type_next = present_sync ? type_sync : drive_comm_pkg::CARD_TYPE_RESET;

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cmd_src_reg   <= drive_comm_pkg::CMD_SOURCE_RESET;
         framing_reg   <= drive_comm_pkg::FRAMING_RESET;
         card_type_reg <= drive_comm_pkg::CARD_TYPE_RESET;
      end else begin
         cmd_src_reg   <= cmd_src_next;
         framing_reg   <= framing_next;
         card_type_reg <= card_type_next;
      end
   end

   // ----------------------------------------------------------------
   // Command steering
   // ----------------------------------------------------------------
   wire        run_link  = cmd_src_reg[drive_comm_pkg::SRC_RUN_BIT];
   wire        freq_link = cmd_src_reg[drive_comm_pkg::SRC_FREQ_BIT];
   wire [1:0]  run_next  = run_link ? link_run_in : local_run_in;
   wire [15:0] freq_next = freq_link ? link_freq_in : local_freq_in;

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         run_cmd_out        <= 2'h0;
         freq_cmd_out       <= 16'h0000;
         run_from_link_out  <= 1'b0;
         freq_from_link_out <= 1'b0;
         framing_sel_out    <= drive_comm_pkg::FRAMING_RESET;
      end else begin
         run_cmd_out        <= run_next;
         freq_cmd_out       <= freq_next;
         run_from_link_out  <= run_link;
         freq_from_link_out <= freq_link;
         framing_sel_out    <= framing_reg;
      end
   end

   // ----------------------------------------------------------------
   // Parameter read and error decode
   // ----------------------------------------------------------------
   logic [15:0] rd_word;
   logic        mapped;

   always_comb begin
      rd_word = 16'h0000;
      mapped  = 1'b1;
      case (param_addr_in)
         drive_comm_pkg::ADDR_TRIP_FLAGS:
            rd_word = trip_sync & drive_comm_pkg::TRIP_USED_MASK;
         drive_comm_pkg::ADDR_INPUT_TERM:  rd_word = {5'h00, in_term_sync};
         drive_comm_pkg::ADDR_OUTPUT_TERM: rd_word = {8'h00, out_term_sync};
         drive_comm_pkg::ADDR_ANALOG_A:    rd_word = analog_a_in;
         drive_comm_pkg::ADDR_ANALOG_B:    rd_word = analog_b_in;
         drive_comm_pkg::ADDR_ANALOG_I:    rd_word = analog_i_in;
         drive_comm_pkg::ADDR_SHAFT_SPEED: rd_word = shaft_speed_in;
         drive_comm_pkg::ADDR_UNIT_SELECT: rd_word = unit_select_in;
         drive_comm_pkg::ADDR_POLE_COUNT:  rd_word = pole_count_in;
         drive_comm_pkg::ADDR_CUSTOM_REV:  rd_word = custom_rev_in;
         drive_comm_pkg::ADDR_CARD_TYPE:   rd_word = {13'h0000, card_type_reg};
         drive_comm_pkg::ADDR_CMD_SOURCE:  rd_word = {14'h0000, cmd_src_reg};
         drive_comm_pkg::ADDR_CARD_REV:    rd_word = card_revision_in;
         drive_comm_pkg::ADDR_FRAMING:     rd_word = {14'h0000, framing_reg};
         drive_comm_pkg::ADDR_SERIES_CODE: rd_word = SERIES_CODE;
         // Station number and line speed live in another group
         default:                          mapped  = 1'b0;
      endcase
   end

   // Only the two option settings take writes; common-area words keep nothing
   wire writable = hit_src || hit_frame;
   wire wr_bad   = param_wr_in && (!writable || !wdata_ok);
   wire err_next = !mapped || wr_bad;

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         param_ack_out   <= 1'b0;
         param_err_out   <= 1'b0;
         param_rdata_out <= 16'h0000;
      end else begin
         param_ack_out   <= param_req_in;
         param_err_out   <= param_req_in && err_next;
         param_rdata_out <= (param_req_in && !param_wr_in && mapped) ? rd_word : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   a_src_in_range: assert property (
      wr_req && hit_src && param_wdata_in <= 16'h0003
      |=> cmd_src_reg == $past(param_wdata_in[1:0]))
      else $error("legal selector write not stored");
   a_src_refuse: assert property (
      wr_req && hit_src && param_wdata_in > 16'h0003
      |=> param_err_out && param_ack_out && $stable(cmd_src_reg))
      else $error("out-of-range selector write not refused");
   a_run_only_link: assert property (
      cmd_src_reg == 2'h1 && $stable(cmd_src_reg)
      |=> run_cmd_out == $past(link_run_in) && freq_cmd_out == $past(local_freq_in))
      else $error("selector 1 steering wrong");
   a_freq_only_link: assert property (
      cmd_src_reg == 2'h2
      |=> run_cmd_out == $past(local_run_in) && freq_cmd_out == $past(link_freq_in)
          && freq_from_link_out && !run_from_link_out)
      else $error("selector 2 steering wrong");
   a_both_link: assert property (
      cmd_src_reg == 2'h3
      |=> run_cmd_out == $past(link_run_in) && freq_cmd_out == $past(link_freq_in))
      else $error("selector 3 steering wrong");
   a_type_read_only: assert property (
      wr_req && param_addr_in == drive_comm_pkg::ADDR_CARD_TYPE |=> param_err_out)
      else $error("card type write accepted");
   a_type_absent: assert property (
      !present_sync |=> card_type_reg == 3'h0)
      else $error("card type shown with no card");
   a_common_no_write: assert property (
      wr_req && param_addr_in <= drive_comm_pkg::ADDR_COMMON_LAST |=> param_err_out)
      else $error("common-area write accepted");
   a_trip_unused_zero: assert property (
      param_req_in && !param_wr_in && param_addr_in == drive_comm_pkg::ADDR_TRIP_FLAGS
      |=> param_rdata_out[5] == 1'b0 && param_rdata_out[11] == 1'b0
          && param_rdata_out[0] == $past(trip_sync[0]))
      else $error("trip word bits wrong");
   a_ack_timing: assert property (
      param_ack_out == $past(param_req_in) && (param_ack_out || !param_err_out))
      else $error("answer not one cycle after request");

   c_src_write: cover property (src_we ##1 param_ack_out && !param_err_out);
   c_src_both: cover property (cmd_src_reg == 2'h3 ##1 run_from_link_out);
   c_trip_read: cover property (param_req_in && !param_wr_in
                                && param_addr_in == drive_comm_pkg::ADDR_TRIP_FLAGS);
   c_bad_addr: cover property (param_req_in && !mapped ##1 param_err_out);

endmodule

//--- bench/net_master_model.sv
// Network master model: issues one parameter read or write per call
module net_master_model (
   input  wire logic        clk_sys_in,
   input  wire logic        param_ack_in,
   input  wire logic        param_err_in,
   input  wire logic [15:0] param_rdata_in,
   output logic             param_req_out,
   output logic             param_wr_out,
   output logic      [15:0] param_addr_out,
   output logic      [15:0] param_wdata_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      param_req_out   = 1'b0;
      param_wr_out    = 1'b0;
      param_addr_out  = 16'h0000;
      param_wdata_out = 16'h0000;
   end

   // Station number and line speed live elsewhere, never addressed here
   task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                         output logic [15:0] rdata, output logic err, output logic seen);
      int n;
      @(posedge clk_sys_in);
      #1;
      param_req_out   = 1'b1;
      param_wr_out    = wr;
      param_addr_out  = addr;
      param_wdata_out = wdata;
      @(posedge clk_sys_in);
      #1;
      param_req_out = 1'b0;
      seen          = 1'b0;
      rdata         = 16'h0000;
      err           = 1'b0;
      for (n = 0; n < 4 && !seen; n++) begin
         if (param_ack_in === 1'b1) begin
            seen  = 1'b1;
            rdata = param_rdata_in;
            err   = param_err_in;
         end else begin
            @(posedge clk_sys_in);
            #1;
         end
      end
      // Stale qualifiers are scrambled so a late sample cannot pass by luck
      param_addr_out  = ~addr;
      param_wdata_out = ~wdata;
   endtask
endmodule

//--- bench/drive_comm_status_registers_bench.sv
// Testbench: parameter map reads, writes, steering and reset behaviour
module drive_comm_status_registers_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_sys = 1'b0, rst_b = 1'b0, req, wr, ack, err, present = 1'b0, rfl, ffl;
   logic [15:0] addr, wdata, rdata, trip = 16'h0000, freq_out;
   logic [2:0]  ctype = 3'h0;
   logic [1:0]  loc_run = 2'h1, lnk_run = 2'h2;
   logic [15:0] loc_freq = 16'h1234, lnk_freq = 16'h5678;
   logic [15:0] an_a = 16'h1111, an_b = 16'h2222, an_i = 16'h3333;
   logic [10:0] in_term = 11'h5A5;
   logic [7:0]  out_term = 8'hC3;
   logic [1:0]  run_out, fsel;
   int          err_count = 0;
   int          n_checks = 0;
   logic [15:0] tab_addr [11] = '{16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0014,
                                 16'h0015, 16'h001A, 16'h001B, 16'h001C, 16'hFFFF,
                                 16'h9603};
   logic [15:0] tab_exp [11] = '{16'h05A5, 16'h00C3, 16'h1111, 16'h2222, 16'h3333,
                                16'h0E10, 16'h0001, 16'h0004, 16'h0102, 16'h00A5,
                                16'h0202};

   always #2 clk_sys = ~clk_sys;

   drive_comm_status_registers u_dut (
      .clk_sys_in(clk_sys), .rst_b_in(rst_b), .param_req_in(req), .param_wr_in(wr),
      .param_addr_in(addr), .param_wdata_in(wdata), .param_ack_out(ack),
      .param_err_out(err), .param_rdata_out(rdata), .trip_cond_in(trip),
      .input_term_in(in_term), .output_term_in(out_term), .card_present_in(present),
      .card_type_in(ctype), .card_revision_in(16'h0202), .analog_a_in(an_a),
      .analog_b_in(an_b), .analog_i_in(an_i), .shaft_speed_in(16'h0E10),
      .unit_select_in(16'h0001), .pole_count_in(16'h0004), .custom_rev_in(16'h0102),
      .local_run_in(loc_run), .local_freq_in(loc_freq), .link_run_in(lnk_run),
      .link_freq_in(lnk_freq), .run_cmd_out(run_out), .freq_cmd_out(freq_out),
      .run_from_link_out(rfl), .freq_from_link_out(ffl), .framing_sel_out(fsel));

   net_master_model u_master (
      .clk_sys_in(clk_sys), .param_ack_in(ack), .param_err_in(err),
      .param_rdata_in(rdata), .param_req_out(req), .param_wr_out(wr),
      .param_addr_out(addr), .param_wdata_out(wdata));

   // ---------------------------------------------
   // Compare and access helpers
   // ---------------------------------------------
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: flag got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                       input logic [15:0] exp, input logic exp_err);
      logic [15:0] got;
      logic        e;
      logic        seen;
      u_master.access(w, a, d, got, e, seen);
      chk_bit(seen, 1'b1);
      chk_word(got, exp);
      chk_bit(e, exp_err);
   endtask

   task automatic test_done;
      $display("Checks %0d, errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic do_reset;
      rst_b = 1'b0;
      repeat (16) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      logic [15:0] v;
      do_reset();
      xfer(1'b0, 16'h9602, 16'h0000, 16'h0000, 1'b0);
      for (v = 16'h0000; v < 16'h0004; v++) begin
         // Fresh source values each pass, so a stuck steering path shows
         lnk_run  = 2'h2 ^ v[1:0];
         loc_run  = ~lnk_run;
         lnk_freq = 16'h5678 + v;
         loc_freq = 16'h1234 + v;
         xfer(1'b1, 16'h9602, v, 16'h0000, 1'b0);
         repeat (3) @(posedge clk_sys);
         #1;
         chk_bit(rfl, v[0]);
         chk_bit(ffl, v[1]);
         chk_word({14'h0000, run_out}, {14'h0000, v[0] ? lnk_run : loc_run});
         chk_word(freq_out, v[1] ? lnk_freq : loc_freq);
         xfer(1'b0, 16'h9602, 16'h0000, v, 1'b0);
      end
      xfer(1'b1, 16'h9602, 16'h0004, 16'h0000, 1'b1);
      xfer(1'b0, 16'h9602, 16'h0000, 16'h0003, 1'b0);
      xfer(1'b1, 16'h9601, 16'h0001, 16'h0000, 1'b1);
      present = 1'b1;
      for (v = 16'h0000; v < 16'h0008; v++) begin
         ctype = v[2:0];
         repeat (5) @(posedge clk_sys);
         xfer(1'b0, 16'h9601, 16'h0000, v, 1'b0);
      end
      // Absent card reads zero even with a stale type code on the pins
      present = 1'b0;
      repeat (5) @(posedge clk_sys);
      xfer(1'b0, 16'h9601, 16'h0000, 16'h0000, 1'b0);
      trip = 16'hFFFF;
      repeat (4) @(posedge clk_sys);
      xfer(1'b0, 16'h000F, 16'h0000, 16'hF7DF, 1'b0);
      trip = 16'h0820;
      repeat (4) @(posedge clk_sys);
      xfer(1'b0, 16'h000F, 16'h0000, 16'h0000, 1'b0);
      xfer(1'b1, 16'h000F, 16'h0001, 16'h0000, 1'b1);
      xfer(1'b0, 16'h0016, 16'h0000, 16'h0000, 1'b1);
      for (int i = 0; i < 11; i++)
         xfer(1'b0, tab_addr[i], 16'h0000, tab_exp[i], 1'b0);
      xfer(1'b1, 16'h963C, 16'h0002, 16'h0000, 1'b0);
      xfer(1'b1, 16'h9602, 16'h0003, 16'h0000, 1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      chk_word({14'h0000, fsel}, 16'h0002);
      do_reset();
      chk_bit(rfl, 1'b0);
      xfer(1'b0, 16'h9602, 16'h0000, 16'h0000, 1'b0);
      xfer(1'b0, 16'h963C, 16'h0000, 16'h0000, 1'b0);
      test_done();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      test_done();
   end
endmodule
